// ---- swc_debounce.sv ----
// one input: two-flop synchroniser followed by a tick-based debounce
// assumes i_tick is a one-cycle pulse on the same clock; limit 0 = no filter
`timescale 1ns/100ps
`default_nettype none
module swc_debounce (
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	input  wire logic       i_async,
	input  wire logic       i_tick,
	input  wire logic [7:0] i_limit,
	output logic            o_level
);
	logic       meta_reg;   // first flop, read only by sync_reg
	logic       sync_reg;   // second flop
	logic [7:0] cnt_reg;    // ticks the new level has stood
	logic [7:0] cnt_next;
	logic       level_next;

	// idle high, so a line that is released at reset makes no event
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	// the level moves only after the new value held for i_limit ticks
	always_comb begin
		cnt_next   = cnt_reg;
		level_next = o_level;
		if (sync_reg == o_level) begin
			cnt_next = 8'h00;
		end else if (i_limit == 8'h00 || cnt_reg >= i_limit) begin
			level_next = sync_reg;
			cnt_next   = 8'h00;
		end else if (i_tick) begin
			cnt_next = cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_reg <= 8'h00;
			o_level <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			o_level <= level_next;
		end
	end
endmodule
`default_nettype wire

// ---- swc_pkg.sv ----
// package for the system wake-up control block: offsets, fields, timing
// assumes a 20 MHz standby clock and the plain register port of swc_top
package swc_pkg;

	// clock and timing
	localparam int unsigned CLK_HZ            = 20_000_000;
	localparam int unsigned CLK_MHZ           = CLK_HZ / 1_000_000;
	// debounce and blink base tick, in ns
	localparam int unsigned TICK_NS           = 1_000_000;
	localparam int unsigned TICK_CYCLES       = (TICK_NS / 1000) * CLK_MHZ;
	// power-fell pulse width, in ns (least time, rounded up)
	localparam int unsigned POWER_FELL_NS     = 1000;
	localparam int unsigned POWER_FELL_CYCLES =
		(POWER_FELL_NS * CLK_MHZ + 999) / 1000;
	// watchdog pulse width, in ns (least time, rounded up)
	localparam int unsigned WATCHDOG_NS       = 2000;
	localparam int unsigned WATCHDOG_CYCLES   =
		(WATCHDOG_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TICK_W            = 15;
	localparam int unsigned PULSE_W           = 8;

	// register bus
	localparam int unsigned ADDR_W            = 6;
	localparam logic [5:0] OFS_WAKE_STATUS    = 6'h00;
	localparam logic [5:0] OFS_WAKE_ENABLE    = 6'h04;
	localparam logic [5:0] OFS_MGMT_ENABLE    = 6'h08;
	localparam logic [5:0] OFS_DEBOUNCE       = 6'h0C;
	localparam logic [5:0] OFS_POWER_CTRL     = 6'h10;
	localparam logic [5:0] OFS_LED_CTRL       = 6'h14;
	localparam logic [5:0] OFS_GP_EDGE        = 6'h18;
	localparam logic [5:0] OFS_STATE          = 6'h1C;
	localparam logic [5:0] OFS_LEVELS         = 6'h20;

	// event sources, one status bit each
	localparam int unsigned NUM_GP            = 16;
	localparam int unsigned SRC_RING_A        = 16;
	localparam int unsigned SRC_RING_B        = 17;
	localparam int unsigned SRC_KBD_CLK       = 18;
	localparam int unsigned SRC_PTR_DAT       = 21;
	localparam int unsigned SRC_PWR_BTN       = 22;
	localparam int unsigned SRC_SLP_BTN       = 23;
	localparam int unsigned NUM_SRC           = 24;
	// synchronised-only levels after the sources
	localparam int unsigned SYN_MAIN_GOOD     = 24;
	localparam int unsigned NUM_SYNC          = 27;
	// inputs that pass the programmable debounce filter
	localparam logic [26:0] DEB_MASK          = 27'h0C0FFFF;

	// power control fields
	localparam int unsigned PC_SUPPLY_ON      = 0;
	localparam int unsigned PC_BTN_TOGGLE     = 1;
	localparam int unsigned PC_BTN_PASS       = 2;
	localparam logic [2:0] PC_RESET           = 3'h4;

	// led control fields
	localparam int unsigned LED_A_LSB         = 0;
	localparam int unsigned LED_B_LSB         = 2;
	localparam int unsigned LED_DUAL          = 4;
	localparam int unsigned LED_RATE_LSB      = 8;
	localparam logic [1:0] LED_OFF            = 2'h0;
	localparam logic [1:0] LED_ON             = 2'h1;
	localparam logic [1:0] LED_BLINK          = 2'h2;
	localparam logic [15:0] LED_RESET         = 16'h0000;
	localparam logic [7:0] DEBOUNCE_RESET     = 8'h10;

	// decoded sleep state
	typedef enum logic [1:0] {
		SLEEP_WORKING,
		SLEEP_SUSPEND,
		SLEEP_OFF,
		SLEEP_ILLEGAL
	} swc_sleep_e;

	// one register bus request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} swc_bus_req_s;

endpackage

// ---- swc_supply_model.sv ----
// behavioural power supply and sleep-state controller facing swc_top
// demand comes from the open-drain wire with its pull-up already applied
`timescale 1ns/100ps
`default_nettype none
module swc_supply_model #(
	parameter int DELAY = 4
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	input  wire logic       i_demand_pin,
	input  wire logic [1:0] i_sleep_code,
	output logic            o_main_power_good,
	output logic            o_suspend_n,
	output logic            o_off_n
);
	int cnt; // cycles the supply has lagged the demand
	// a low wire asks for power; the supply settles DELAY + 1 cycles later
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_main_power_good <= 1'b0;
			cnt               <= 0;
		end else if (!i_demand_pin == o_main_power_good) begin
			cnt <= 0;
		end else if (cnt == DELAY) begin
			o_main_power_good <= !i_demand_pin;
			cnt               <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// code 0 working, 1 suspend, 2 off; the high-low pair never appears
	assign o_suspend_n = i_sleep_code == 2'h0;
	assign o_off_n     = i_sleep_code != 2'h2;
endmodule
`default_nettype wire

// ---- swc_tb_top.sv ----
// self-checking bench for swc_top beside the supply and sleep model
// assumes a tick of 4 cycles so debounce and blink stay short
`timescale 1ns/100ps
`default_nettype none
module swc_tb_top;
	import swc_pkg::*;
	logic         i_sys_clk, i_reset, i_watchdog_timeout, first;
	swc_bus_req_s i_bus;
	logic [31:0]  o_rdata, got;
	logic [15:0]  i_event_gp_input;
	logic [3:0]   ps2;        // keyboard clock, data, pointer clock, data
	logic [1:0]   sleep_code; // state the partner is asked to report
	logic         i_ring_indicate_a_n, i_ring_indicate_b_n;
	logic         i_power_button_in_n, i_sleep_button_in_n, i_main_power_good;
	logic         i_sleep_state_suspend_n, i_sleep_state_off_n;
	logic         o_power_button_out, o_power_button_out_oe;
	logic         o_system_control_irq_n, o_system_control_irq_n_oe;
	logic         o_system_mgmt_irq_n, o_system_mgmt_irq_n_oe;
	logic         o_supply_on_request_n, o_supply_on_request_n_oe;
	logic         o_indicator_drive_a, o_indicator_drive_b;
	logic         o_main_power_fell_pulse, o_watchdog_pulse_out_n;
	wire          supply_pin; // open-drain wire, pulled up when released
	int           fail_count, comparisons;
	assign supply_pin = o_supply_on_request_n_oe ? o_supply_on_request_n : 1'b1;
	swc_top #(.TICK_LEN(4)) swc_top_i (
		.i_sys_clk, .i_reset, .i_bus, .o_rdata, .i_event_gp_input,
		.i_ring_indicate_a_n, .i_ring_indicate_b_n,
		.i_kbd_clock_line(ps2[0]), .i_kbd_data_line(ps2[1]),
		.i_pointer_clock_line(ps2[2]), .i_pointer_data_line(ps2[3]),
		.i_power_button_in_n, .i_sleep_button_in_n, .i_sleep_state_suspend_n,
		.i_sleep_state_off_n, .i_main_power_good, .i_watchdog_timeout,
		.o_power_button_out, .o_power_button_out_oe, .o_system_control_irq_n,
		.o_system_control_irq_n_oe, .o_system_mgmt_irq_n,
		.o_system_mgmt_irq_n_oe, .o_supply_on_request_n,
		.o_supply_on_request_n_oe, .o_indicator_drive_a, .o_indicator_drive_b,
		.o_main_power_fell_pulse, .o_watchdog_pulse_out_n
	);
	swc_supply_model swc_supply_model_i (
		.i_sys_clk, .i_reset, .i_demand_pin(supply_pin),
		.i_sleep_code(sleep_code), .o_main_power_good(i_main_power_good),
		.o_suspend_n(i_sleep_state_suspend_n), .o_off_n(i_sleep_state_off_n)
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle strobes; the bus idles one edge after each access
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge i_sys_clk) i_bus <= '{1'b1, 1'b0, a, d};
		@(posedge i_sys_clk) i_bus <= '0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge i_sys_clk) i_bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge i_sys_clk) i_bus <= '0;
		#1 got = o_rdata;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
		rd(a);
		chk(got, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	// status must hold bit b alone; irq pins as given; then cleared
	task automatic ev(input int b, input logic [1:0] irq);
		repeat (40) begin
			rd(OFS_WAKE_STATUS);
			if (got[b] === 1'b1) break;
		end
		chk(got, 32'h1 << b);
		chk(32'({o_system_control_irq_n_oe, o_system_mgmt_irq_n_oe}), 32'(irq));
		wr(OFS_WAKE_STATUS, 32'h00FFFFFF);
		cyc(2);
		chk(32'({o_system_control_irq_n_oe, o_system_mgmt_irq_n_oe}), 32'h0);
	endtask
	function automatic logic [31:0] leds();
		return 32'({o_indicator_drive_a, o_indicator_drive_b});
	endfunction
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fail_count++;
		$display("mismatch at %0t: run timed out", $time);
		test_done();
	end
	initial begin
		fail_count = 0;
		comparisons = 0;
		i_reset = 1'b1;
		i_bus = '0;
		i_event_gp_input = 16'hFFFF;
		ps2 = 4'hF;
		sleep_code = 2'h0;
		{i_ring_indicate_a_n, i_ring_indicate_b_n} = 2'h3;
		{i_power_button_in_n, i_sleep_button_in_n} = 2'h3;
		i_watchdog_timeout = 1'b0;
		repeat (3) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		cyc(1);
		chk(32'({o_power_button_out_oe, o_supply_on_request_n_oe,
			o_system_control_irq_n_oe, o_system_mgmt_irq_n_oe}), 32'h0);
		chk(leds(), 32'h0);
		rchk(OFS_DEBOUNCE, 32'h10);
		rchk(OFS_POWER_CTRL, 32'h4);
		rchk(OFS_GP_EDGE, 32'h0);
		wr(6'h3C, 32'hFFFFFFFF);
		rchk(6'h3C, 32'h0);
		rchk(OFS_WAKE_STATUS, 32'h0);
		$display("test reset done");
		wr(OFS_DEBOUNCE, 32'h0);
		wr(OFS_WAKE_ENABLE, 32'h10000);
		wr(OFS_MGMT_ENABLE, 32'h20001);
		@(posedge i_sys_clk) i_ring_indicate_a_n <= 1'b0;
		ev(SRC_RING_A, 2'b10);
		@(posedge i_sys_clk) i_ring_indicate_b_n <= 1'b0;
		ev(SRC_RING_B, 2'b01);
		@(posedge i_sys_clk) i_ring_indicate_a_n <= 1'b1;
		@(posedge i_sys_clk) i_ring_indicate_b_n <= 1'b1;
		// each line both ways while main power is still off
		for (int k = 0; k < 4; k++) begin
			repeat (2) begin
				@(posedge i_sys_clk) ps2[k] <= ~ps2[k];
				ev(SRC_KBD_CLK + k, 2'b00);
			end
		end
		$display("test ring and line events done");
		wr(OFS_GP_EDGE, 32'h1);
		@(posedge i_sys_clk) i_event_gp_input <= 16'hFFFC;
		ev(1, 2'b00);
		@(posedge i_sys_clk) i_event_gp_input <= 16'hFFFF;
		ev(0, 2'b01);
		wr(OFS_DEBOUNCE, 32'h2);
		@(posedge i_sys_clk) i_event_gp_input[1] <= 1'b0;
		@(posedge i_sys_clk) i_event_gp_input[1] <= 1'b1;
		cyc(30);
		rchk(OFS_WAKE_STATUS, 32'h0);
		@(posedge i_sys_clk) i_event_gp_input[1] <= 1'b0;
		ev(1, 2'b00);
		@(posedge i_sys_clk) i_event_gp_input[1] <= 1'b1;
		wr(OFS_DEBOUNCE, 32'h0);
		$display("test general inputs done");
		wr(OFS_POWER_CTRL, 32'h6);
		@(posedge i_sys_clk) i_power_button_in_n <= 1'b0;
		ev(SRC_PWR_BTN, 2'b00);
		chk(32'({o_power_button_out_oe, o_supply_on_request_n_oe}), 32'h3);
		@(posedge i_sys_clk) i_power_button_in_n <= 1'b1;
		cyc(20);
		rd(OFS_STATE);
		chk(32'({o_power_button_out_oe, got[3:2]}), 32'h3);
		for (int s = 0; s < 3; s++) begin
			@(posedge i_sys_clk) sleep_code <= 2'(s);
			cyc(4);
			rd(OFS_STATE);
			chk(32'(got[1:0]), s);
		end
		@(posedge i_sys_clk) i_sleep_button_in_n <= 1'b0;
		ev(SRC_SLP_BTN, 2'b00);
		@(posedge i_sys_clk) i_sleep_button_in_n <= 1'b1;
		wr(OFS_POWER_CTRL, 32'h4);
		repeat (40) begin
			cyc(1);
			if (o_main_power_fell_pulse === 1'b1) break;
		end
		chk(32'(o_main_power_fell_pulse), 32'h1);
		chk(32'(o_supply_on_request_n_oe), 32'h0);
		$display("test power and sleep done");
		wr(OFS_LED_CTRL, 32'h5);
		cyc(2);
		chk(leds(), 32'h3);
		wr(OFS_LED_CTRL, 32'h15);
		cyc(2);
		chk(leds(), 32'h2);
		wr(OFS_LED_CTRL, 32'hA);
		cyc(2);
		first = o_indicator_drive_a;
		repeat (20) begin
			cyc(1);
			if (o_indicator_drive_a !== first) break;
		end
		chk(leds(), 32'({~first, ~first}));
		$display("test leds done");
		@(posedge i_sys_clk) i_watchdog_timeout <= 1'b1;
		@(posedge i_sys_clk) i_watchdog_timeout <= 1'b0;
		#1 chk(32'(o_watchdog_pulse_out_n), 32'h0);
		cyc(41);
		chk(32'(o_watchdog_pulse_out_n), 32'h1);
		$display("test watchdog done");
		test_done();
	end
endmodule
`default_nettype wire

// ---- swc_top.sv ----
// system wake-up control: event capture, sleep decode, power and led pins
// assumes standby clock i_sys_clk, pins asynchronous, bus on the same clock
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module swc_top #(
	parameter int unsigned TICK_LEN = swc_pkg::TICK_CYCLES
) (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_reset,
	// register port
	input  wire swc_pkg::swc_bus_req_s i_bus,
	output logic [31:0]               o_rdata,
	// wake and button pins
	input  wire logic [15:0]          i_event_gp_input,
	input  wire logic                 i_ring_indicate_a_n,
	input  wire logic                 i_ring_indicate_b_n,
	input  wire logic                 i_kbd_clock_line,
	input  wire logic                 i_kbd_data_line,
	input  wire logic                 i_pointer_clock_line,
	input  wire logic                 i_pointer_data_line,
	input  wire logic                 i_power_button_in_n,
	input  wire logic                 i_sleep_button_in_n,
	input  wire logic                 i_sleep_state_suspend_n,
	input  wire logic                 i_sleep_state_off_n,
	input  wire logic                 i_main_power_good,
	// time-out strobe from watchdog logic on this clock
	input  wire logic                 i_watchdog_timeout,
	// open-drain outputs: value and enable
	output logic                      o_power_button_out,
	output logic                      o_power_button_out_oe,
	output logic                      o_system_control_irq_n,
	output logic                      o_system_control_irq_n_oe,
	output logic                      o_system_mgmt_irq_n,
	output logic                      o_system_mgmt_irq_n_oe,
	output logic                      o_supply_on_request_n,
	output logic                      o_supply_on_request_n_oe,
	// push-pull outputs
	output logic                      o_indicator_drive_a,
	output logic                      o_indicator_drive_b,
	output logic                      o_main_power_fell_pulse,
	output logic                      o_watchdog_pulse_out_n
);
	import swc_pkg::*;

	// base tick
	logic [TICK_W-1:0]   tick_cnt_reg;   // cycles within one tick
	wire                 tick;           // one-cycle tick strobe

	// synchronised and filtered inputs
	wire [NUM_SYNC-1:0]  raw_in;         // pins as they arrive
	wire [NUM_SYNC-1:0]  clean;          // after sync and debounce
	logic [NUM_SYNC-1:0] prev_reg;       // clean, one cycle old
	wire [NUM_SYNC-1:0]  fall;           // high to low
	wire [NUM_SYNC-1:0]  rise;           // low to high
	wire [NUM_SYNC-1:0]  change;         // either way

	// software registers
	logic [NUM_SRC-1:0]  status_reg;     // sticky events
	logic [NUM_SRC-1:0]  status_next;
	logic [NUM_SRC-1:0]  wake_en_reg;    // sources to the control irq
	logic [NUM_SRC-1:0]  mgmt_en_reg;    // sources to the management irq
	logic [7:0]          deb_limit_reg;  // debounce ticks
	logic [2:0]          pctrl_reg;      // power control bits
	logic [2:0]          pctrl_next;
	logic [15:0]         led_reg;        // led control
	logic [NUM_GP-1:0]   gp_edge_reg;    // 1 = rising edge is active
	logic [31:0]         rdata_next;

	// decode
	wire                 wr_hit_status;
	wire                 wr_hit_wake;
	wire                 wr_hit_mgmt;
	wire                 wr_hit_deb;
	wire                 wr_hit_pctrl;
	wire                 wr_hit_led;
	wire                 wr_hit_edge;
	wire [NUM_SRC-1:0]   events;         // this cycle's new events
	wire [NUM_SRC-1:0]   clr_mask;       // write-one-to-clear bits
	swc_sleep_e          sleep_state;    // decoded sleep inputs

	// pulses and leds
	logic [PULSE_W-1:0]  fell_cnt_reg;
	logic [PULSE_W-1:0]  wdog_cnt_reg;
	wire                 fell_edge;
	logic [7:0]          blink_cnt_reg;
	logic                blink_phase_reg;
	wire [1:0]           mode_a;
	wire [1:0]           mode_b;
	wire                 lit_a;
	wire                 lit_b;
	wire                 sci_active;
	wire                 smi_active;
	wire                 btn_pass;

	// free-running tick; the length is a parameter so a test can shorten it
	assign tick = (tick_cnt_reg == TICK_W'(TICK_LEN - 1));

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			tick_cnt_reg <= '0;
		end else if (tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
		end
	end

	// every pin goes through the same sync cell; only some get a filter
	// main good enters inverted: its idle (off) level then matches the
	// cell's reset value of one, so standby power-up makes no false loss
	assign raw_in = {i_sleep_state_off_n, i_sleep_state_suspend_n,
		~i_main_power_good, i_sleep_button_in_n, i_power_button_in_n,
		i_pointer_data_line, i_pointer_clock_line, i_kbd_data_line,
		i_kbd_clock_line, i_ring_indicate_b_n, i_ring_indicate_a_n,
		i_event_gp_input};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SYNC; gi++) begin : g_in
			swc_debounce u_deb (
				.i_sys_clk (i_sys_clk),
				.i_reset   (i_reset),
				.i_async   (raw_in[gi]),
				.i_tick    (tick),
				.i_limit   (DEB_MASK[gi] ? deb_limit_reg : 8'h00),
				.o_level   (clean[gi])
			);
		end
	endgenerate

	// one-cycle history for edge detection; idle high matches the cells
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			prev_reg <= '1;
		end else begin
			prev_reg <= clean;
		end
	end

	assign fall   = prev_reg & ~clean;
	assign rise   = ~prev_reg & clean;
	assign change = prev_reg ^ clean;

	// gp: chosen edge; ring: going low; lines: any change; buttons: press
	assign events[NUM_GP-1:0] =
		(gp_edge_reg & rise[NUM_GP-1:0]) |
		(~gp_edge_reg & fall[NUM_GP-1:0]);
	assign events[SRC_RING_B:SRC_RING_A] =
		fall[SRC_RING_B:SRC_RING_A];
	// no gating by main power: the lines are watched in any state
	assign events[SRC_PTR_DAT:SRC_KBD_CLK] =
		change[SRC_PTR_DAT:SRC_KBD_CLK];
	assign events[SRC_PWR_BTN] = fall[SRC_PWR_BTN];
	assign events[SRC_SLP_BTN] = fall[SRC_SLP_BTN];

	// register write decode
	assign wr_hit_status = i_bus.wr && (i_bus.addr == OFS_WAKE_STATUS);
	assign wr_hit_wake   = i_bus.wr && (i_bus.addr == OFS_WAKE_ENABLE);
	assign wr_hit_mgmt   = i_bus.wr && (i_bus.addr == OFS_MGMT_ENABLE);
	assign wr_hit_deb    = i_bus.wr && (i_bus.addr == OFS_DEBOUNCE);
	assign wr_hit_pctrl  = i_bus.wr && (i_bus.addr == OFS_POWER_CTRL);
	assign wr_hit_led    = i_bus.wr && (i_bus.addr == OFS_LED_CTRL);
	assign wr_hit_edge   = i_bus.wr && (i_bus.addr == OFS_GP_EDGE);
	assign clr_mask      = wr_hit_status ? i_bus.wdata[NUM_SRC-1:0] : '0;

	// new events beat a clear in the same cycle so nothing is lost
	assign status_next = (status_reg & ~clr_mask) | events;

	// sleep-state decode; the illegal pair is reported, not acted on
	always_comb begin
		unique case ({clean[SYN_MAIN_GOOD+1], clean[SYN_MAIN_GOOD+2]})
			2'b11:   sleep_state = SLEEP_WORKING;
			2'b01:   sleep_state = SLEEP_SUSPEND;
			2'b00:   sleep_state = SLEEP_OFF;
			default: sleep_state = SLEEP_ILLEGAL;
		endcase
	end

	// supply demand: a write sets it, else a press may toggle it
	always_comb begin
		pctrl_next = pctrl_reg;
		if (wr_hit_pctrl) begin
			pctrl_next = i_bus.wdata[2:0];
		end else if (events[SRC_PWR_BTN] && pctrl_reg[PC_BTN_TOGGLE]) begin
			pctrl_next[PC_SUPPLY_ON] = ~pctrl_reg[PC_SUPPLY_ON];
		end
	end

	// software registers; reset leaves every output idle
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			status_reg    <= '0;
			wake_en_reg   <= '0;
			mgmt_en_reg   <= '0;
			deb_limit_reg <= DEBOUNCE_RESET;
			pctrl_reg     <= PC_RESET;
			led_reg       <= LED_RESET;
			gp_edge_reg   <= '0;
		end else begin
			status_reg    <= status_next;
			pctrl_reg     <= pctrl_next;
			if (wr_hit_wake) begin
				wake_en_reg <= i_bus.wdata[NUM_SRC-1:0];
			end
			if (wr_hit_mgmt) begin
				mgmt_en_reg <= i_bus.wdata[NUM_SRC-1:0];
			end
			if (wr_hit_deb) begin
				deb_limit_reg <= i_bus.wdata[7:0];
			end
			if (wr_hit_led) begin
				led_reg <= i_bus.wdata[15:0];
			end
			if (wr_hit_edge) begin
				gp_edge_reg <= i_bus.wdata[NUM_GP-1:0];
			end
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (i_bus.addr)
			OFS_WAKE_STATUS: rdata_next[NUM_SRC-1:0] = status_reg;
			OFS_WAKE_ENABLE: rdata_next[NUM_SRC-1:0] = wake_en_reg;
			OFS_MGMT_ENABLE: rdata_next[NUM_SRC-1:0] = mgmt_en_reg;
			OFS_DEBOUNCE:    rdata_next[7:0]         = deb_limit_reg;
			OFS_POWER_CTRL:  rdata_next[2:0]         = pctrl_reg;
			OFS_LED_CTRL:    rdata_next[15:0]        = led_reg;
			OFS_GP_EDGE:     rdata_next[NUM_GP-1:0]  = gp_edge_reg;
			OFS_STATE:       rdata_next[4:0] = {blink_phase_reg,
				pctrl_reg[PC_SUPPLY_ON], ~clean[SYN_MAIN_GOOD],
				2'(sleep_state)};
			OFS_LEVELS:      rdata_next[NUM_SYNC-1:0] = clean ^ 27'h1000000;
			default:         rdata_next = 32'h0000_0000;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= i_bus.rd ? rdata_next : 32'h0000_0000;
		end
	end

	// interrupt conditions; a source can feed either line or both
	assign sci_active = |(status_reg & wake_en_reg);
	assign smi_active = |(status_reg & mgmt_en_reg);
	assign btn_pass   = pctrl_reg[PC_BTN_PASS] && !clean[SRC_PWR_BTN];

	// open-drain pins: value is always low, the enable pulls the wire
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_system_control_irq_n_oe <= 1'b0;
			o_system_mgmt_irq_n_oe    <= 1'b0;
			o_supply_on_request_n_oe  <= 1'b0;
			o_power_button_out_oe     <= 1'b0;
		end else begin
			o_system_control_irq_n_oe <= sci_active;
			o_system_mgmt_irq_n_oe    <= smi_active;
			o_supply_on_request_n_oe  <= pctrl_reg[PC_SUPPLY_ON];
			o_power_button_out_oe     <= btn_pass;
		end
	end

	assign o_system_control_irq_n = 1'b0;
	assign o_system_mgmt_irq_n    = 1'b0;
	assign o_supply_on_request_n  = 1'b0;
	assign o_power_button_out     = 1'b0;

	// main supply loss: the inverted good level rises
	assign fell_edge = rise[SYN_MAIN_GOOD];

	// fixed-width pulses: load on the cause, count down, active while > 1
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			fell_cnt_reg            <= '0;
			wdog_cnt_reg            <= '0;
			o_main_power_fell_pulse <= 1'b0;
			o_watchdog_pulse_out_n  <= 1'b1;
		end else begin
			if (fell_edge) begin
				fell_cnt_reg <= PULSE_W'(POWER_FELL_CYCLES);
			end else if (fell_cnt_reg != '0) begin
				fell_cnt_reg <= fell_cnt_reg - PULSE_W'(1);
			end
			if (i_watchdog_timeout) begin
				wdog_cnt_reg <= PULSE_W'(WATCHDOG_CYCLES);
			end else if (wdog_cnt_reg != '0) begin
				wdog_cnt_reg <= wdog_cnt_reg - PULSE_W'(1);
			end
			// push-pull, strong enough to trigger a peripheral power cycle
			o_main_power_fell_pulse <= fell_edge ||
				(fell_cnt_reg > PULSE_W'(1));
			o_watchdog_pulse_out_n  <= !(i_watchdog_timeout ||
				(wdog_cnt_reg > PULSE_W'(1)));
		end
	end

	// a new time-out while a pulse runs restarts it, so the low pulse grows longer
	// blink phase: toggles every (rate + 1) ticks, shared by both leds
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			blink_cnt_reg   <= 8'h00;
			blink_phase_reg <= 1'b0;
		end else if (tick) begin
			if (blink_cnt_reg >= led_reg[LED_RATE_LSB +: 8]) begin
				blink_cnt_reg   <= 8'h00;
				blink_phase_reg <= ~blink_phase_reg;
			end else begin
				blink_cnt_reg <= blink_cnt_reg + 8'h01;
			end
		end
	end

	assign mode_a = led_reg[LED_A_LSB +: 2];
	assign mode_b = led_reg[LED_B_LSB +: 2];
	assign lit_a  = (mode_a == LED_ON) ||
		((mode_a == LED_BLINK) && blink_phase_reg);
	assign lit_b  = (mode_b == LED_ON) ||
		((mode_b == LED_BLINK) && blink_phase_reg);

	// dual-colour: the two dies share one package, so a wins over b
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_indicator_drive_a <= 1'b0;
			o_indicator_drive_b <= 1'b0;
		end else begin
			o_indicator_drive_a <= lit_a;
			o_indicator_drive_b <= led_reg[LED_DUAL] ?
				(lit_b && !lit_a) : lit_b;
		end
	end
endmodule
`default_nettype wire

// ---- swc_top_chk.sv ----
// checker for swc_top: reset state, pulse widths, supply demand, irq hold
// bound into swc_top below; sees only its ports
`timescale 1ns/100ps
`default_nettype none
module swc_top_chk (
	input wire logic                  i_sys_clk,
	input wire logic                  i_reset,
	input wire swc_pkg::swc_bus_req_s i_bus,
	input wire logic                  i_main_power_good,
	input wire logic                  i_watchdog_timeout,
	input wire logic                  o_power_button_out_oe,
	input wire logic                  o_system_control_irq_n_oe,
	input wire logic                  o_system_mgmt_irq_n_oe,
	input wire logic                  o_supply_on_request_n_oe,
	input wire logic                  o_main_power_fell_pulse,
	input wire logic                  o_watchdog_pulse_out_n
);
	import swc_pkg::*;
	logic [7:0] wd_cnt;   // low cycles since the last time-out strobe
	logic [7:0] fell_cnt; // high cycles of the current fell pulse
	// width counters; a new time-out strobe restarts wd_cnt, as it does the pulse; fell_cnt keeps counting
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			wd_cnt   <= 8'h00;
			fell_cnt <= 8'h00;
		end else begin
			wd_cnt   <= i_watchdog_timeout ? 8'h00
				: wd_cnt + {7'h00, !o_watchdog_pulse_out_n};
			fell_cnt <= o_main_power_fell_pulse ? fell_cnt + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// a write to the power control word
	sequence s_pc_write;
		i_bus.wr && i_bus.addr == OFS_POWER_CTRL;
	endsequence
	// a bus write in one of the last three cycles
	sequence s_recent_write;
		$past(i_bus.wr) || $past(i_bus.wr, 2) || $past(i_bus.wr, 3);
	endsequence
	property p_supply;
		logic v;
		(s_pc_write, v = i_bus.wdata[0]) |-> ##2 o_supply_on_request_n_oe == v;
	endproperty
	AST_RESET_IDLE: assert property ($past(i_reset) |->
		!o_power_button_out_oe && !o_system_control_irq_n_oe
		&& !o_system_mgmt_irq_n_oe && !o_supply_on_request_n_oe
		&& o_watchdog_pulse_out_n && !o_main_power_fell_pulse)
		else $error("output active right after reset");
	AST_WDOG_START: assert property (
		i_watchdog_timeout |=> !o_watchdog_pulse_out_n)
		else $error("watchdog pulse did not start");
	AST_WDOG_WIDTH: assert property (
		$rose(o_watchdog_pulse_out_n) |-> wd_cnt == 8'h28)
		else $error("watchdog pulse width wrong");
	AST_FELL_START: assert property (
		$fell(i_main_power_good) |-> ##[1:6] o_main_power_fell_pulse)
		else $error("no fell pulse after supply loss");
	AST_FELL_WIDTH: assert property (
		$fell(o_main_power_fell_pulse) |-> fell_cnt == 8'h14)
		else $error("fell pulse width wrong");
	AST_SUPPLY_WRITE: assert property (p_supply)
		else $error("supply demand pin does not follow write");
	AST_SCI_HOLD: assert property (
		$fell(o_system_control_irq_n_oe) |-> s_recent_write)
		else $error("control irq dropped without a write");
	AST_SMI_HOLD: assert property (
		$fell(o_system_mgmt_irq_n_oe) |-> s_recent_write)
		else $error("mgmt irq dropped without a write");
endmodule
bind swc_top swc_top_chk swc_top_chk_i (
	.i_sys_clk, .i_reset, .i_bus, .i_main_power_good, .i_watchdog_timeout,
	.o_power_button_out_oe, .o_system_control_irq_n_oe,
	.o_system_mgmt_irq_n_oe, .o_supply_on_request_n_oe,
	.o_main_power_fell_pulse, .o_watchdog_pulse_out_n
);
`default_nettype wire
